// *** hw/iorp_top.v ***
// Pad input capture path with output element and AXI4-Lite config slave
//
// What this block does
// R1 - Each core path picks the raw pad input or the stored input on its own.
// R2 - One shared enable gates the input element, the output element or both.
// R3 - The shared enable is active high and cannot be inverted here.
// R4 - Power-up or global set/reset forces the init value; clear is default.
// R5 - In flip-flop mode the element loads on a rising edge if enabled.
// R6 - Latch mode passes data while the clock is low and enable high.
// R7 - An unconnected enable acts as a constant high.
// R8 - One set-or-clear choice covers start-up and global set/reset alike.
// R9 - No user set or reset exists; only the global net initialises elements.
// R10 - Input element data passes a selectable delay, largest by default.
// R11 - The basic variant offers only full delay or no delay.
// R12 - The extended variant offers full, partial or no delay.
// R13 - The global net acts at power-up, reconfiguration and when driven.
// R14 - The delay setting only chooses a tap and leaves capture unchanged.
`timescale 1ns/1ps
`include "iorp_defines.vh"

module iorp_top (
	input  wire                    aclk,
	input  wire                    aresetn,
	// Pad and core side
	input  wire                    pad_in,
	input  wire                    element_clock,
	input  wire                    shared_clock_enable_pin,
	input  wire                    global_set_reset_net,
	input  wire                    core_output_data,
	output reg                     core_input_path_a,
	output reg                     core_input_path_b,
	output wire                    pad_out,
	// AXI4-Lite write address
	input  wire [`IORP_ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]              s_axi_awprot,
	input  wire                    s_axi_awvalid,
	output wire                    s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output wire                    s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	// AXI4-Lite read address
	input  wire [`IORP_ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]              s_axi_arprot,
	input  wire                    s_axi_arvalid,
	output wire                    s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Register decode, shared by read and write paths
	function [1:0] iorp_decode;
		input [`IORP_ADDR_W-1:0] addr;
		begin
			if (addr == `IORP_CFG_ADDR)
				iorp_decode = 2'h1;
			else if (addr == `IORP_STAT_ADDR)
				iorp_decode = 2'h2;
			else
				iorp_decode = 2'h0;
		end
	endfunction

	// Byte-lane merge of a write into an old word
	function [31:0] iorp_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0]  strb;
		integer      k;
		begin
			iorp_merge = old_word;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k])
					iorp_merge[k*8 +: 8] = new_word[k*8 +: 8];
			end
		end
	endfunction

	// Delay code to tap index, by family variant
	function [1:0] iorp_tap_sel;
		input       extended;
		input [1:0] code;
		begin
			if (extended) begin
				// R12 three delay settings
				case (code)
					`IORP_DLY_PART: iorp_tap_sel = `IORP_TAP_PART;
					`IORP_DLY_ZERO: iorp_tap_sel = `IORP_TAP_NONE;
					default:        iorp_tap_sel = `IORP_TAP_FULL;
				endcase
			end else begin
				// R11 full or no delay only
				if (code == `IORP_DLY_ZERO)
					iorp_tap_sel = `IORP_TAP_NONE;
				else
					iorp_tap_sel = `IORP_TAP_FULL;
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Configuration and status
	// ------------------------------------------------------------
	reg  [31:0] cfg;
	wire [31:0] status;
	wire        in_q;
	wire        out_q;
	wire        delayed_in;

	wire        sel_a      = cfg[`IORP_CFG_SEL_A];
	wire        sel_b      = cfg[`IORP_CFG_SEL_B];
	wire        ce_to_in   = cfg[`IORP_CFG_CE_IN];
	wire        ce_to_out  = cfg[`IORP_CFG_CE_OUT];
	wire        latch_mode = cfg[`IORP_CFG_LATCH];
	wire        init_in    = cfg[`IORP_CFG_INIT_IN];
	wire        init_out   = cfg[`IORP_CFG_INIT_OUT];
	wire        extended   = cfg[`IORP_CFG_EXT];
	wire        ce_conn    = cfg[`IORP_CFG_CE_CONN];
	wire [1:0]  dly_code   = cfg[`IORP_CFG_DLY_HI:`IORP_CFG_DLY_LO];

	assign status = {28'h0000000,
	                 global_set_reset_net,
	                 delayed_in,
	                 out_q,
	                 in_q};

	// ------------------------------------------------------------
	// Shared clock enable routing
	// ------------------------------------------------------------
	wire ce_level;
	wire ce_in_elem;
	wire ce_out_elem;

	// R3 no inversion
	// R7 unconnected reads high
	assign ce_level    = ce_conn ? shared_clock_enable_pin : 1'b1;
	// R2 enable to either or both
	assign ce_in_elem  = ce_to_in  ? ce_level : 1'b1;
	assign ce_out_elem = ce_to_out ? ce_level : 1'b1;

	// ------------------------------------------------------------
	// Input delay and storage elements
	// ------------------------------------------------------------
	wire [1:0] tap_sel;

	// R10 full delay default
	// R14 tap choice only
	assign tap_sel = iorp_tap_sel(extended, dly_code);

	iorp_delay_line u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tap_sel (tap_sel),
		.din     (pad_in),
		.dout    (delayed_in)
	);

	// R9 global net only
	// R13 global net any time
	iorp_storage_elem u_in_elem (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.force_init (global_set_reset_net),
		.init_set   (init_in),
		.latch_mode (latch_mode),
		.elem_clock (element_clock),
		.ce         (ce_in_elem),
		.d          (delayed_in),
		.q          (in_q)
	);

	// Output element shares mode and clock but has its own init choice
	iorp_storage_elem u_out_elem (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.force_init (global_set_reset_net),
		.init_set   (init_out),
		.latch_mode (latch_mode),
		.elem_clock (element_clock),
		.ce         (ce_out_elem),
		.d          (core_output_data),
		.q          (out_q)
	);

	assign pad_out = out_q;

	// ------------------------------------------------------------
	// Core path selection
	// ------------------------------------------------------------
	// Both paths retimed once; the stored path still lags the direct one by the element stage and delay taps
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_input_path_a <= 1'b0;
			core_input_path_b <= 1'b0;
		end else begin
			// R1 independent path select
			core_input_path_a <= sel_a ? in_q : pad_in;
			core_input_path_b <= sel_b ? in_q : pad_in;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	reg                    aw_held;
	reg [`IORP_ADDR_W-1:0] aw_addr;
	reg                    w_held;
	reg [31:0]             w_data;
	reg [3:0]              w_strb;

	wire                    aw_take;
	wire                    w_take;
	wire                    aw_have;
	wire                    w_have;
	wire                    wr_fire;
	wire [`IORP_ADDR_W-1:0] wr_addr;
	wire [31:0]             wr_data;
	wire [3:0]              wr_strb;
	wire [1:0]              wr_hit;

	// New address or data waits until the response is taken
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign aw_have       = aw_held || aw_take;
	assign w_have        = w_held || w_take;
	assign wr_fire       = aw_have && w_have;
	assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data       = w_held ? w_data : s_axi_wdata;
	assign wr_strb       = w_held ? w_strb : s_axi_wstrb;
	assign wr_hit        = iorp_decode(wr_addr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= {`IORP_ADDR_W{1'b0}};
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `IORP_RESP_OKAY;
			cfg          <= `IORP_CFG_RESET;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_hit == 2'h1) begin
					cfg <= iorp_merge(cfg, wr_data, wr_strb) &
					       `IORP_CFG_MASK;
					s_axi_bresp <= `IORP_RESP_OKAY;
				end else if (wr_hit == 2'h2)
					// Status is read-only; write dropped quietly
					s_axi_bresp <= `IORP_RESP_OKAY;
				else
					s_axi_bresp <= `IORP_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	wire       ar_take;
	wire [1:0] rd_hit;

	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign rd_hit        = iorp_decode(s_axi_araddr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `IORP_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				case (rd_hit)
					2'h1: begin
						s_axi_rdata <= cfg;
						s_axi_rresp <= `IORP_RESP_OKAY;
					end
					2'h2: begin
						s_axi_rdata <= status;
						s_axi_rresp <= `IORP_RESP_OKAY;
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `IORP_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Protection bits carry no meaning for this slave
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule // iorp_top

// *** hw/iorp_defines.vh ***
// Shared constants for the pad input capture path and its register slave
`ifndef IORP_DEFINES_VH
`define IORP_DEFINES_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define IORP_ADDR_W        4
`define IORP_CFG_ADDR      4'h0
`define IORP_STAT_ADDR     4'h4
`define IORP_WORD_LSB      2
`define IORP_RESP_OKAY     2'h0
`define IORP_RESP_SLVERR   2'h2

// ------------------------------------------------------------
// Configuration word fields and reset value
// ------------------------------------------------------------
`define IORP_CFG_SEL_A     0
`define IORP_CFG_SEL_B     1
`define IORP_CFG_CE_IN     2
`define IORP_CFG_CE_OUT    3
`define IORP_CFG_LATCH     4
`define IORP_CFG_INIT_IN   5
`define IORP_CFG_DLY_LO    6
`define IORP_CFG_DLY_HI    7
`define IORP_CFG_EXT       8
`define IORP_CFG_CE_CONN   9
`define IORP_CFG_INIT_OUT  10
`define IORP_CFG_MASK      32'h000007ff
`define IORP_CFG_RESET     32'h0000000c

// ------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------
`define IORP_STAT_IN_Q     0
`define IORP_STAT_OUT_Q    1
`define IORP_STAT_DLY      2
`define IORP_STAT_GLOBAL   3

// ------------------------------------------------------------
// Delay settings and tap counts
// ------------------------------------------------------------
`define IORP_DLY_FULL      2'h0
`define IORP_DLY_PART      2'h1
`define IORP_DLY_ZERO      2'h2
`define IORP_TAPS_FULL     2
`define IORP_TAP_FULL      2'h2
`define IORP_TAP_PART      2'h1
`define IORP_TAP_NONE      2'h0

`endif

// *** hw/iorp_delay_line.v ***
// Tapped delay line in front of the input storage element
`timescale 1ns/1ps
`include "iorp_defines.vh"

module iorp_delay_line (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [1:0] tap_sel,
	input  wire       din,
	output wire       dout
);

	wire [`IORP_TAPS_FULL:0] taps;
	assign taps[0] = din;

	genvar i;
	generate
		for (i = 1; i <= `IORP_TAPS_FULL; i = i + 1) begin : g_tap
			reg stage;
			always @(posedge aclk) begin
				if (!aresetn)
					stage <= 1'b0;
				else
					stage <= taps[i-1];
			end
			assign taps[i] = stage;
		end
	endgenerate

	// Tap choice only; no effect on how data is captured
	assign dout = taps[tap_sel];

endmodule // iorp_delay_line

// *** hw/iorp_storage_elem.v ***
// Configurable flip-flop or latch storage element of the pad block
`timescale 1ns/1ps

module iorp_storage_elem (
	input  wire aclk,
	input  wire aresetn,
	input  wire force_init,
	input  wire init_set,
	input  wire latch_mode,
	input  wire elem_clock,
	input  wire ce,
	input  wire d,
	output reg  q
);

	reg clock_prev;

	always @(posedge aclk) begin
		if (!aresetn) begin
			// Configuration resets to clear, matching this value
			q          <= 1'b0;
			// Starts high so a clock held high gives no false edge
			clock_prev <= 1'b1;
		end else begin
			clock_prev <= elem_clock;
			// R4 init overrides all
			// R8 one init choice
			if (force_init)
				q <= init_set;
			// R6 latch transparent low
			else if (latch_mode) begin
				if (!elem_clock && ce)
					q <= d;
			// R5 rising edge load
			end else if (elem_clock && !clock_prev && ce)
				q <= d;
		end
	end

endmodule // iorp_storage_elem

// *** test/iorp_pad_model.sv ***
// External driver that sits on the pad input
`timescale 1ns/1ps

module iorp_pad_model (
	input  wire aclk,
	input  wire level,
	output reg  pad
);
	// ------------------------------------------------------------
	// Pad drive
	// ------------------------------------------------------------
	// Driver is always enabled, so the pad never floats
	always @* begin
		pad = level;
	end
endmodule // iorp_pad_model

// *** test/iorp_top_properties.sv ***
// Concurrent checks on the ports of the pad capture path
`timescale 1ns/1ps
`include "iorp_defines.vh"

module iorp_chk (
	input wire                    aclk,
	input wire                    aresetn,
	input wire                    pad_in,
	input wire                    element_clock,
	input wire                    shared_clock_enable_pin,
	input wire                    global_set_reset_net,
	input wire                    core_output_data,
	input wire                    core_input_path_a,
	input wire                    core_input_path_b,
	input wire                    pad_out,
	input wire [`IORP_ADDR_W-1:0] s_axi_awaddr,
	input wire                    s_axi_awvalid,
	input wire                    s_axi_awready,
	input wire [31:0]             s_axi_wdata,
	input wire                    s_axi_wvalid,
	input wire                    s_axi_wready,
	input wire [1:0]              s_axi_bresp,
	input wire                    s_axi_bvalid,
	input wire                    s_axi_bready,
	input wire [31:0]             s_axi_rdata,
	input wire                    s_axi_rvalid,
	input wire                    s_axi_rready,
	input wire                    s_axi_arready
);
	// ------------------------------------------------------------
	// Shadow of the configuration word
	// ------------------------------------------------------------
	// Full-word writes with address and data together are assumed
	reg  [10:0] sh;
	reg         eclk_d;
	wire        wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && s_axi_awaddr == `IORP_CFG_ADDR;
	always @(posedge aclk) begin
		eclk_d <= element_clock;
		if (!aresetn)
			sh <= `IORP_CFG_RESET;
		else if (wr)
			sh <= s_axi_wdata[10:0];
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_out_rise;
		!element_clock ##1 (element_clock && !global_set_reset_net &&
			!sh[4] && (shared_clock_enable_pin || !sh[3] || !sh[9]));
	endsequence
	sequence s_out_idle;
		aresetn ##1 (!global_set_reset_net && !sh[4] &&
			!(element_clock && !eclk_d));
	endsequence

	direct_path_a: assert property (
		!sh[0] |=> core_input_path_a == $past(pad_in))
		else $error("path a not the raw pad");
	direct_path_b: assert property (
		!sh[1] |=> core_input_path_b == $past(pad_in))
		else $error("path b not the raw pad");
	enable_hold_a: assert property (
		!global_set_reset_net && !shared_clock_enable_pin &&
		sh[3] && sh[9] |=> $stable(pad_out))
		else $error("output moved with enable low");
	init_out_a: assert property (
		global_set_reset_net |=>
		pad_out == $past(sh[`IORP_CFG_INIT_OUT]))
		else $error("output not at init value");
	init_in_a: assert property (
		global_set_reset_net ##1 sh[0] |=>
		core_input_path_a == $past(sh[`IORP_CFG_INIT_IN], 2))
		else $error("input element not at init value");
	ff_load_a: assert property (
		s_out_rise |=> pad_out == $past(core_output_data))
		else $error("output element missed a load");
	ff_hold_a: assert property (
		s_out_idle |=> $stable(pad_out))
		else $error("output element changed without edge");
	write_resp_a: assert property (wr |=> s_axi_bvalid &&
		s_axi_bresp == `IORP_RESP_OKAY)
		else $error("config write not answered okay");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	read_busy_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
endmodule // iorp_chk

bind iorp_top iorp_chk i_iorp_chk (.aclk, .aresetn, .pad_in, .element_clock,
	.shared_clock_enable_pin, .global_set_reset_net, .core_output_data,
	.core_input_path_a, .core_input_path_b, .pad_out, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_arready);

// *** test/tb_top.sv ***
// Self-checking bench of the pad capture path
`timescale 1ns/1ps
`include "iorp_defines.vh"

module tb_top;
	reg         aclk, aresetn, lvl, eclk, ce, gnet, odat;
	reg  [3:0]  awaddr, araddr;
	reg  [31:0] wdata;
	reg         awvalid, wvalid, bready, arvalid, rready;
	wire        pad_in, pa, pb, pad_out, awready, wready, bvalid;
	wire        arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	integer     n_fail, samples_checked;

	iorp_pad_model i_iorp_pad_model (.aclk(aclk), .level(lvl), .pad(pad_in));
	iorp_top i_iorp_top (.aclk(aclk), .aresetn(aresetn), .pad_in(pad_in),
		.element_clock(eclk), .shared_clock_enable_pin(ce),
		.global_set_reset_net(gnet), .core_output_data(odat),
		.core_input_path_a(pa), .core_input_path_b(pb), .pad_out(pad_out),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask

	task wr(input [3:0] a, input [31:0] d, input [1:0] er);
		reg done;
		begin
			done = 1'b0;
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!done) begin
				@(posedge aclk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					bready <= 1'b0;
					done = 1'b1;
					chk(bresp, er);
				end
			end
		end
	endtask

	task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
		reg done;
		begin
			done = 1'b0;
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (!done) begin
				@(posedge aclk);
				if (arready)
					arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					rready <= 1'b0;
					done = 1'b1;
					chk(rdata, ed);
					chk(rresp, er);
				end
			end
		end
	endtask

	// Output data mirrors the pad so both elements see the same data
	task step(input p, input e, input c, input g);
		begin
			@(posedge aclk);
			lvl <= p;
			eclk <= e;
			ce <= c;
			gnet <= g;
			odat <= p;
			repeat (4) @(posedge aclk);
			#1;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_regs;
		begin
			rd(`IORP_CFG_ADDR, `IORP_CFG_RESET, `IORP_RESP_OKAY);
			wr(`IORP_CFG_ADDR, 32'hffffffff, `IORP_RESP_OKAY);
			rd(`IORP_CFG_ADDR, `IORP_CFG_MASK, `IORP_RESP_OKAY);
			wr(`IORP_STAT_ADDR, 32'h0, `IORP_RESP_OKAY);
			rd(`IORP_CFG_ADDR, `IORP_CFG_MASK, `IORP_RESP_OKAY);
			wr(4'h8, 32'h0, `IORP_RESP_SLVERR);
			rd(4'hc, 32'h0, `IORP_RESP_SLVERR);
			$display("t_regs done");
		end
	endtask

	task t_direct;
		begin
			wr(`IORP_CFG_ADDR, 32'h80, `IORP_RESP_OKAY);
			step(1, 0, 1, 1);
			chk(pa, 1);
			chk(pb, 1);
			step(0, 0, 1, 0);
			chk(pa, 0);
			$display("t_direct done");
		end
	endtask

	// Latch follows data, so the count to the core is taps plus two
	task t_delay;
		integer c, n;
		reg [1:0] taps;
		begin
			for (c = 0; c < 8; c = c + 1) begin
				taps = (c[1:0] == 2'h2) ? 2'h0 :
					(c[2] && c[1:0] == 2'h1) ? 2'h1 : 2'h2;
				wr(`IORP_CFG_ADDR, {c[2], c[1:0], 6'h11}, `IORP_RESP_OKAY);
				step(0, 0, 1, 0);
				@(posedge aclk);
				lvl <= 1'b1;
				n = 0;
				while (pa !== 1'b1 && n < 9) begin
					@(posedge aclk);
					#1;
					n = n + 1;
				end
				chk(n, taps + 2);
			end
			$display("t_delay done");
		end
	endtask

	task t_latch;
		begin
			wr(`IORP_CFG_ADDR, 32'h295, `IORP_RESP_OKAY);
			step(0, 0, 1, 0);
			chk(pa, 0);
			step(1, 1, 1, 0);
			chk(pa, 0);
			step(1, 0, 0, 0);
			chk(pa, 0);
			step(1, 0, 1, 0);
			chk(pa, 1);
			wr(`IORP_CFG_ADDR, 32'h95, `IORP_RESP_OKAY);
			step(0, 0, 0, 0);
			chk(pa, 0);
			$display("t_latch done");
		end
	endtask

	task t_ff;
		begin
			wr(`IORP_CFG_ADDR, 32'h287, `IORP_RESP_OKAY);
			step(1, 0, 1, 0);
			chk(pa, 0);
			step(1, 1, 1, 0);
			chk(pa, 1);
			chk(pb, 1);
			chk(pad_out, 1);
			step(0, 1, 1, 0);
			chk(pa, 1);
			step(0, 0, 0, 0);
			step(0, 1, 0, 0);
			chk(pa, 1);
			step(0, 0, 1, 0);
			step(0, 1, 1, 0);
			chk(pa, 0);
			$display("t_ff done");
		end
	endtask

	task t_global;
		begin
			wr(`IORP_CFG_ADDR, 32'h4a1, `IORP_RESP_OKAY);
			step(0, 0, 1, 1);
			chk(pa, 1);
			chk(pad_out, 1);
			rd(`IORP_STAT_ADDR, 32'h0000000b, `IORP_RESP_OKAY);
			step(0, 0, 1, 0);
			chk(pa, 1);
			wr(`IORP_CFG_ADDR, 32'h81, `IORP_RESP_OKAY);
			step(1, 1, 1, 1);
			chk(pa, 0);
			chk(pad_out, 0);
			$display("t_global done");
		end
	endtask

	// ------------------------------------------------------------
	// Verdict, clock, watchdog and main sequence
	// ------------------------------------------------------------
	task give_verdict;
		begin
			$display("checks %0d, mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Whole run is a few hundred cycles; this allows more than a hundred times that
	initial begin
		#(25 * 40000);
		n_fail = n_fail + 1;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict;
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		{lvl, eclk, ce, gnet, odat} = 5'h0;
		{awaddr, araddr, wdata} = 40'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		chk(pa, 0);
		chk(pad_out, 0);
		t_regs;
		t_direct;
		t_delay;
		t_latch;
		t_ff;
		t_global;
		give_verdict;
	end
endmodule // tb_top
